/* logic/pic_pkg.sv */
// Shared constants and carrier types for the pulse input counter
package pic_pkg;

   // ==========================================================
   // Widths and sizes
   localparam int CNT_W      = 32;
   localparam int DATA_W     = 32;
   localparam int DIV_W      = 64;
   localparam int BUCKET_W   = 24;
   localparam int WIN_IDX_W  = 7;
   localparam int SUM_W      = BUCKET_W + WIN_IDX_W;
   localparam int NUM_CH     = 4;
   localparam int CH_SEL_W   = 3;
   localparam int DIV_CNT_W  = 7;

   // ==========================================================
   // Channel selection range
   localparam logic [CH_SEL_W-1:0] CH_MIN = 3'h1;
   localparam logic [CH_SEL_W-1:0] CH_MAX = 3'h4;

   // ==========================================================
   // Sample window: 0 to 60 s in 0.5 s buckets
   localparam int unsigned WIN_MAX_S     = 60;
   localparam int unsigned HALF_PER_SEC  = 2;
   localparam int unsigned WIN_DEPTH     = WIN_MAX_S * HALF_PER_SEC;
   localparam logic [WIN_IDX_W-1:0] WIN_LAST = WIN_IDX_W'(WIN_DEPTH - 1);

   // ==========================================================
   // Timing
   localparam longint CLK_HZ     = 40_000_000;
   localparam longint SCAN_MS    = 500;
   localparam longint MOMENT_MS  = 1000;
   localparam longint MS_PER_S   = 1000;
   localparam longint SCAN_CYC   = SCAN_MS * CLK_HZ / MS_PER_S;
   localparam longint MOMENT_CYC = MOMENT_MS * CLK_HZ / MS_PER_S;

   // ==========================================================
   // Rate period scaling in seconds
   localparam logic [12:0] SEC_PER_SEC  = 13'h0001;
   localparam logic [12:0] SEC_PER_MIN  = 13'h003c;
   localparam logic [12:0] SEC_PER_HOUR = 13'h0e10;

   typedef enum logic [1:0] {
      PIC_PER_SEC  = 2'h0,
      PIC_PER_MIN  = 2'h1,
      PIC_PER_HOUR = 2'h2
   } pic_period_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [CH_SEL_W-1:0] channel_sel;
      logic                use_remote;
      logic                latched_mode;
      pic_period_t         time_period;
      logic [WIN_IDX_W-1:0] sample_half_s;
      logic [DATA_W-1:0]   pulses_per_eu;
      logic [DATA_W-1:0]   local_preset;
   } pic_cfg_t;

   typedef struct packed {
      logic preset_reached_flag;
      logic count_full_flag;
      logic fail_flag;
   } pic_flags_t;

endpackage

/* logic/pic_divider.sv */
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module pic_divider (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire logic                    clear,
   input  wire logic                    start,
   input  wire logic [pic_pkg::DIV_W-1:0] num,
   input  wire logic [pic_pkg::DIV_W-1:0] den,
   output logic                         busy,
   output logic                         done,
   output logic [pic_pkg::DIV_W-1:0]    quot
);

   typedef enum logic [1:0] {
      PIC_DV_IDLE = 2'b01,
      PIC_DV_RUN  = 2'b10
   } pic_dv_state_t;

   pic_dv_state_t                     state;
   logic [pic_pkg::DIV_W:0]           rem;
   logic [pic_pkg::DIV_W-1:0]         q;
   logic [pic_pkg::DIV_W-1:0]         d;
   logic [pic_pkg::DIV_CNT_W-1:0]     cnt;

   wire logic [pic_pkg::DIV_W:0] rem_sh  = {rem[pic_pkg::DIV_W-1:0], q[pic_pkg::DIV_W-1]};
   wire logic                    fits    = rem_sh >= {1'b0, d};
   wire logic [pic_pkg::DIV_W:0] rem_sub = rem_sh - {1'b0, d};
   wire logic                    last    = cnt == pic_pkg::DIV_CNT_W'(pic_pkg::DIV_W - 1);

   assign busy = state == PIC_DV_RUN;

   always_ff @(posedge clk)
   begin
      if (!resetn || clear)
      begin
         state <= PIC_DV_IDLE;
         done  <= 1'b0;
         quot  <= '0;
         rem   <= '0;
         q     <= '0;
         d     <= '0;
         cnt   <= '0;
      end
      else
      begin
         done <= 1'b0;
         unique case (state)
            PIC_DV_IDLE:
               if (start)
               begin
                  rem   <= '0;
                  q     <= num;
                  d     <= den;
                  cnt   <= '0;
                  state <= PIC_DV_RUN;
               end
            PIC_DV_RUN:
            begin
               rem <= fits ? rem_sub : rem_sh;
               q   <= {q[pic_pkg::DIV_W-2:0], fits};
               cnt <= cnt + 1'b1;
               if (last)
               begin
                  // A zero divisor reports zero rather than all ones
                  quot  <= (d == '0) ? '0 : {q[pic_pkg::DIV_W-2:0], fits};
                  done  <= 1'b1;
                  state <= PIC_DV_IDLE;
               end
            end
         endcase
      end
   end

endmodule

/* logic/pic_rate_window.sv */
// Rolling window of half-second pulse buckets, summed once per scan
`timescale 1ns/1ps
module pic_rate_window (
   input  wire logic                          clk,
   input  wire logic                          resetn,
   input  wire logic                          clear,
   input  wire logic                          pulse,
   input  wire logic                          scan_tick,
   input  wire logic [pic_pkg::WIN_IDX_W-1:0] win_len,
   output logic [pic_pkg::SUM_W-1:0]          sum,
   output logic [pic_pkg::WIN_IDX_W-1:0]      sum_len,
   output logic                               sum_valid
);

   logic [pic_pkg::BUCKET_W-1:0]  ring [pic_pkg::WIN_DEPTH];
   logic [pic_pkg::BUCKET_W-1:0]  cur;
   logic [pic_pkg::WIN_IDX_W-1:0] wr_ptr;
   logic [pic_pkg::WIN_IDX_W-1:0] rd_ptr;
   logic [pic_pkg::WIN_IDX_W-1:0] filled;
   logic [pic_pkg::WIN_IDX_W-1:0] left;
   logic [pic_pkg::SUM_W-1:0]     acc;
   logic                          walking;

   wire logic [pic_pkg::WIN_IDX_W-1:0] wr_nxt = (wr_ptr == pic_pkg::WIN_LAST) ? '0 : wr_ptr + 1'b1;
   wire logic [pic_pkg::WIN_IDX_W-1:0] rd_nxt = (rd_ptr == '0) ? pic_pkg::WIN_LAST : rd_ptr - 1'b1;
   wire logic [pic_pkg::WIN_IDX_W-1:0] fill_nxt =
      (filled == pic_pkg::WIN_IDX_W'(pic_pkg::WIN_DEPTH)) ? filled : filled + 1'b1;
   // A freshly cleared window only averages over the buckets it really has
   wire logic [pic_pkg::WIN_IDX_W-1:0] eff_len = (win_len > fill_nxt) ? fill_nxt : win_len;
   wire logic                          cur_full = &cur;

   // Bucket store has no reset; the fill count says which entries are real
   always_ff @(posedge clk)
   begin
      if (scan_tick)
         ring[wr_ptr] <= cur;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn || clear)
      begin
         cur       <= '0;
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         filled    <= '0;
         left      <= '0;
         acc       <= '0;
         walking   <= 1'b0;
         sum       <= '0;
         sum_len   <= '0;
         sum_valid <= 1'b0;
      end
      else
      begin
         sum_valid <= 1'b0;
         if (scan_tick)
         begin
            cur     <= pic_pkg::BUCKET_W'(pulse);
            wr_ptr  <= wr_nxt;
            filled  <= fill_nxt;
            rd_ptr  <= wr_ptr;
            left    <= eff_len;
            sum_len <= eff_len;
            acc     <= '0;
            walking <= 1'b1;
         end
         else
         begin
            if (pulse && !cur_full)
               cur <= cur + 1'b1;
            if (walking && left != '0)
            begin
               acc    <= acc + pic_pkg::SUM_W'(ring[rd_ptr]);
               rd_ptr <= rd_nxt;
               left   <= left - 1'b1;
            end
            else if (walking)
            begin
               sum       <= acc;
               sum_valid <= 1'b1;
               walking   <= 1'b0;
            end
         end
      end
   end

endmodule

/* logic/pic_pulse_input_counter.sv */
// Pulse input counter channel: count, scaling, preset, rate and flags
`timescale 1ns/1ps

// Functional notes
// (R01) Count selected-line pulses; output is count over weight.
// (R02) Control gives preset, reset, action, hold; gets count and flags.
// (R03) Hold freezes the scaled count output.
// (R04) Reset edge zeros counter and output, clears all flags; a same-cycle hw_fault keeps the fail flag set.
// (R05) Preset flag low below preset, high once count reaches it.
// (R06) Counter logic decides preset; reported flag copies it.
// (R07) Reported flag lags preset output by at most one scan.
// (R08) Zero preset disables detection; flag never rises.
// (R09) Overflow flag sets at full scale; only reset edge clears it.
// (R10) Fail flag sets on fault, stays until reset edge.
// (R11) Rate: window pulses over weight, per second, minute or hour.
// (R12) Window 0 to 60 s in half-second steps, rolled each scan.
// (R13) Config picks remote or local preset.
// (R14) Latched: output and flag stay on until reset.
// (R15) Momentary: one-second pulse, counter zeroed, counting continues.
// (R16) Channel select 1 to 4 picks the input line.
// (R17) Scaled count output may be forced externally.
// (R18) Counter width parameter, default 32; overflow is all ones.
module pic_pulse_input_counter #(
   parameter int unsigned SCAN_CYC   = 32'(pic_pkg::SCAN_CYC),
   parameter int unsigned MOMENT_CYC = 32'(pic_pkg::MOMENT_CYC),
   parameter int          CNT_W      = pic_pkg::CNT_W
) (
   input  wire logic                           clk,
   input  wire logic                           resetn,
   input  wire logic [pic_pkg::NUM_CH-1:0]     pulse_in,
   input  wire pic_pkg::pic_cfg_t              cfg,
   input  wire logic                           hold,
   input  wire logic                           reset_cmd,
   input  wire logic [pic_pkg::DATA_W-1:0]     remote_preset_value,
   input  wire logic                           hw_fault,
   input  wire logic                           force_en,
   input  wire logic [pic_pkg::DATA_W-1:0]     force_value,
   output logic [pic_pkg::DATA_W-1:0]          engineering_units,
   output logic [pic_pkg::DATA_W-1:0]          rate,
   output logic                                preset_output,
   output pic_pkg::pic_flags_t                 flags
);

   // =============================================================
   // Preset output state machine
   typedef enum logic [2:0] {
      PIC_PS_OFF   = 3'b001,
      PIC_PS_LATCH = 3'b010,
      PIC_PS_PULSE = 3'b100
   } pic_ps_state_t;

   pic_ps_state_t               ps_state;
   pic_ps_state_t               next_ps_state;
   logic [31:0]                 moment_cnt;
   logic [CNT_W-1:0]            raw_count;
   logic [CNT_W-1:0]            next_raw_count;
   logic                        pulse_prev;
   logic                        reset_prev;
   logic [31:0]                 scan_cnt;
   logic                        scan_tick;
   logic                        cnt_busy;
   logic                        cnt_done;
   logic [pic_pkg::DIV_W-1:0]   cnt_quot;
   logic                        rate_done;
   logic [pic_pkg::DIV_W-1:0]   rate_quot;
   logic [pic_pkg::SUM_W-1:0]   win_sum;
   logic [pic_pkg::WIN_IDX_W-1:0] win_len;
   logic                        win_valid;

   // =============================================================
   // Input selection and edge detection
   wire logic       chan_ok   = (cfg.channel_sel >= pic_pkg::CH_MIN)
                                && (cfg.channel_sel <= pic_pkg::CH_MAX);            // R16
   wire logic [1:0] chan_idx  = 2'(cfg.channel_sel - pic_pkg::CH_MIN);             // R16
   wire logic       pulse_sel = chan_ok && pulse_in[chan_idx];                      // R16
   wire logic       pulse_edge = pulse_sel && !pulse_prev;                          // R01
   wire logic       rst_edge  = reset_cmd && !reset_prev;                           // R04

   // =============================================================
   // Preset decision, made on raw counts
   wire logic [pic_pkg::DATA_W-1:0] preset_eu =
      cfg.use_remote ? remote_preset_value : cfg.local_preset;                      // R13
   wire logic [pic_pkg::DIV_W-1:0]  preset_counts =
      pic_pkg::DIV_W'(preset_eu) * pic_pkg::DIV_W'(cfg.pulses_per_eu);
   wire logic preset_on  = preset_eu != '0;                                         // R08
   wire logic preset_hit = preset_on
                           && (pic_pkg::DIV_W'(raw_count) >= preset_counts);         // R05
   wire logic count_full = &raw_count;                                              // R18
   wire logic moment_end = moment_cnt == '0;
   // Momentary mode restarts from zero at every hit, so counting never stalls
   wire logic moment_hit = preset_hit && !cfg.latched_mode;                         // R15

   // =============================================================
   // Rate operands: pulses * 2 * seconds-per-period / (halves * weight)
   wire logic [12:0] period_s =
      (cfg.time_period == pic_pkg::PIC_PER_HOUR) ? pic_pkg::SEC_PER_HOUR :
      (cfg.time_period == pic_pkg::PIC_PER_MIN)  ? pic_pkg::SEC_PER_MIN  :
                                                   pic_pkg::SEC_PER_SEC;             // R11
   wire logic [pic_pkg::DIV_W-1:0] rate_num =
      pic_pkg::DIV_W'(win_sum) * pic_pkg::DIV_W'(period_s)
      * pic_pkg::DIV_W'(pic_pkg::HALF_PER_SEC);                                     // R11
   wire logic [pic_pkg::DIV_W-1:0] rate_den =
      pic_pkg::DIV_W'(win_len) * pic_pkg::DIV_W'(cfg.pulses_per_eu);                 // R11
   wire logic rate_ovr = |rate_quot[pic_pkg::DIV_W-1:pic_pkg::DATA_W];
   wire logic cnt_ovr  = |cnt_quot[pic_pkg::DIV_W-1:pic_pkg::DATA_W];

   // =============================================================
   // Raw counter next value
   always_comb
   begin
      next_raw_count = raw_count;
      if (rst_edge)
         next_raw_count = '0; // R04
      else if (moment_hit)
         next_raw_count = CNT_W'(pulse_edge && !hold); // R15
      else if (pulse_edge && !hold && !count_full)
         next_raw_count = raw_count + 1'b1; // R01
   end

   // =============================================================
   // Preset action next state
   always_comb
   begin
      next_ps_state = ps_state;
      unique case (ps_state)
         PIC_PS_OFF:
            if (preset_hit)
               next_ps_state = cfg.latched_mode ? PIC_PS_LATCH : PIC_PS_PULSE; // R06
         PIC_PS_LATCH:
            next_ps_state = PIC_PS_LATCH; // R14
         PIC_PS_PULSE:
            if (moment_end && !moment_hit)
               next_ps_state = PIC_PS_OFF; // R15
         default:
            next_ps_state = PIC_PS_OFF;
      endcase
      if (rst_edge)
         next_ps_state = PIC_PS_OFF; // R04
   end

   // =============================================================
   // Edge history and scan timebase
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pulse_prev <= 1'b0;
         reset_prev <= 1'b0;
         scan_cnt   <= '0;
         scan_tick  <= 1'b0;
      end
      else
      begin
         pulse_prev <= pulse_sel;
         reset_prev <= reset_cmd;
         scan_tick  <= scan_cnt == SCAN_CYC - 1;                                     // R12
         scan_cnt   <= (scan_cnt == SCAN_CYC - 1) ? '0 : scan_cnt + 1'b1;
      end
   end

   // =============================================================
   // Counter, preset output and pulse timer
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         raw_count     <= '0;
         ps_state      <= PIC_PS_OFF;
         preset_output <= 1'b0;
         moment_cnt    <= '0;
      end
      else
      begin
         raw_count     <= next_raw_count;
         ps_state      <= next_ps_state;
         preset_output <= next_ps_state != PIC_PS_OFF;                               // R14
         if (rst_edge)
            moment_cnt <= '0;
         else if (moment_hit)
            moment_cnt <= MOMENT_CYC - 1;                                            // R15
         else if (!moment_end)
            moment_cnt <= moment_cnt - 1'b1;
      end
   end

   // =============================================================
   // Reported flags; a hw_fault set of the fail flag wins over a same-cycle clear
   always_ff @(posedge clk)
   begin
      if (!resetn)
         flags <= '0;
      else
      begin
         flags.preset_reached_flag <= preset_output && !rst_edge; // R07 R02
         // Edge zeros the counter, so overflow cannot re-arm
         flags.count_full_flag     <= !rst_edge && (count_full || flags.count_full_flag); // R09
         flags.fail_flag           <= hw_fault || (flags.fail_flag && !rst_edge); // R10
      end
   end

   // =============================================================
   // Scaled count output
   always_ff @(posedge clk)
   begin
      if (!resetn)
         engineering_units <= '0;
      else if (force_en)
         engineering_units <= force_value; // R17
      else if (rst_edge)
         engineering_units <= '0; // R04
      else if (cnt_done && !hold)
         engineering_units <= cnt_ovr ? '1 : cnt_quot[pic_pkg::DATA_W-1:0]; // R03
   end

   // =============================================================
   // Rate output
   always_ff @(posedge clk)
   begin
      if (!resetn || rst_edge)
         rate <= '0;
      else if (win_valid && win_len == '0)
         rate <= '0; // R12
      else if (rate_done)
         rate <= rate_ovr ? '1 : rate_quot[pic_pkg::DATA_W-1:0]; // R11
   end

   // =============================================================
   // Arithmetic and window
   // Count is re-divided back to back; a reset edge flushes any stale result
   pic_divider u_cnt_div (
      .clk    (clk),
      .resetn (resetn),
      .clear  (rst_edge),
      .start  (!cnt_busy),
      .num    (pic_pkg::DIV_W'(raw_count)),
      .den    (pic_pkg::DIV_W'(cfg.pulses_per_eu)),
      .busy   (cnt_busy),
      .done   (cnt_done),
      .quot   (cnt_quot)
   ); // R01

   pic_divider u_rate_div (
      .clk    (clk),
      .resetn (resetn),
      .clear  (rst_edge),
      .start  (win_valid && win_len != '0),
      .num    (rate_num),
      .den    (rate_den),
      .busy   (),
      .done   (rate_done),
      .quot   (rate_quot)
   ); // R11

   pic_rate_window u_window (
      .clk       (clk),
      .resetn    (resetn),
      .clear     (rst_edge),
      .pulse     (pulse_edge),
      .scan_tick (scan_tick),
      .win_len   (cfg.sample_half_s),
      .sum       (win_sum),
      .sum_len   (win_len),
      .sum_valid (win_valid)
   ); // R12

endmodule

/* testbench/pic_checker.sv */
// Port-level assertions for the pulse input counter
`timescale 1ns/1ps
module pic_checker #(
   parameter int unsigned MOMENT_CYC = 100
) (
   input wire logic                       clk,
   input wire logic                       resetn,
   input wire logic [pic_pkg::NUM_CH-1:0] pulse_in,
   input wire pic_pkg::pic_cfg_t          cfg,
   input wire logic                       hold,
   input wire logic                       reset_cmd,
   input wire logic [pic_pkg::DATA_W-1:0] remote_preset_value,
   input wire logic                       hw_fault,
   input wire logic                       force_en,
   input wire logic [pic_pkg::DATA_W-1:0] force_value,
   input wire logic [pic_pkg::DATA_W-1:0] engineering_units,
   input wire logic [pic_pkg::DATA_W-1:0] rate,
   input wire logic                       preset_output,
   input wire pic_pkg::pic_flags_t        flags
);
   // ==========================================================
   // Helpers
   logic        cmd_d;
   logic        edge_d;
   logic [31:0] hi_cnt;
   wire         rst_edge = reset_cmd && !cmd_d;
   wire  [31:0] act_pre  = cfg.use_remote ? remote_preset_value : cfg.local_preset;

   always_ff @(posedge clk)
   begin
      cmd_d  <= resetn && reset_cmd;
      edge_d <= resetn && rst_edge;
      hi_cnt <= (resetn && preset_output) ? hi_cnt + 32'h1 : 32'h0;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Properties
   property p_fail_set;
      hw_fault |=> flags.fail_flag;
   endproperty
   a_fail_set: assert property (p_fail_set)
      else $error("fail flag missed a fault");
   property p_sticky;
      !rst_edge |=> !$fell(flags.fail_flag) && !$fell(flags.count_full_flag);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("sticky flag dropped without command");
   property p_clear;
      rst_edge && !hw_fault && !force_en |=> engineering_units == 32'h0
         && !flags.fail_flag && !flags.count_full_flag
         && !flags.preset_reached_flag && !preset_output;
   endproperty
   a_clear: assert property (p_clear)
      else $error("reset command did not clear");
   property p_hold;
      hold && !force_en && !rst_edge |=> $stable(engineering_units);
   endproperty
   a_hold: assert property (p_hold)
      else $error("count moved while held");
   property p_force;
      force_en |=> engineering_units == $past(force_value);
   endproperty
   a_force: assert property (p_force)
      else $error("forced value not shown");
   property p_flag_lag;
      $rose(preset_output) && !rst_edge |=> flags.preset_reached_flag;
   endproperty
   a_flag_lag: assert property (p_flag_lag)
      else $error("preset flag lags too long");
   property p_flag_src;
      $rose(flags.preset_reached_flag) |-> $past(preset_output);
   endproperty
   a_flag_src: assert property (p_flag_src)
      else $error("preset flag without output");
   property p_zero_pre;
      $rose(preset_output) |-> $past(act_pre) != 32'h0;
   endproperty
   a_zero_pre: assert property (p_zero_pre)
      else $error("preset hit with zero preset");
   property p_latched;
      cfg.latched_mode && preset_output && !rst_edge |=> preset_output;
   endproperty
   a_latched: assert property (p_latched)
      else $error("latched output dropped");
   property p_moment;
      !cfg.latched_mode && $fell(preset_output) && !edge_d |-> hi_cnt >= MOMENT_CYC;
   endproperty
   a_moment: assert property (p_moment)
      else $error("momentary pulse too short");
endmodule

/* testbench/pic_pulse_source.sv */
// Field pulse source driving the counter input lines
`timescale 1ns/1ps
module pic_pulse_source (
   input  wire logic       clk,
   input  wire logic [2:0] ch,
   input  wire logic       run,
   output logic [3:0]      pulse_in = 4'h0
);
   logic run_q = 1'b0;
   logic tog   = 1'b0;

   always @(posedge clk)
      run_q <= run;

   // Selected line toggles, so every pulse has a low cycle; others carry noise
   always @(negedge clk)
   begin
      tog = run_q ? ~tog : 1'b0;
      for (int i = 0; i < 4; i++)
         pulse_in[i] <= (i + 1 == ch) ? tog : 1'($urandom);
   end
endmodule

/* testbench/pic_pulse_input_counter_tb.sv */
// Self-checking testbench for the pulse input counter
`timescale 1ns/1ps
module pic_pulse_input_counter_tb;
   localparam int unsigned SCAN = 50;
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic [3:0]          pulse_in;
   pic_pkg::pic_cfg_t   cfg = '0;
   logic                hold = 1'b0;
   logic                reset_cmd = 1'b0;
   logic [31:0]         remote_preset_value = 32'h0;
   logic                hw_fault = 1'b0;
   logic                force_en = 1'b0;
   logic [31:0]         force_value = 32'h0;
   logic                run = 1'b0;
   logic [31:0]         engineering_units;
   logic [31:0]         rate;
   logic                preset_output;
   pic_pkg::pic_flags_t flags;
   logic [33:0]         q[$];
   logic [33:0]         e;
   logic [31:0]         got;
   int                  per[3] = '{1, 60, 3600};
   int                  n_mismatch = 0;
   int                  num_checks = 0;
   int                  n;
   int                  w;

   always #12.5 clk = ~clk;

   pic_pulse_input_counter #(.SCAN_CYC(SCAN), .MOMENT_CYC(100), .CNT_W(8))
   pic_pulse_input_counter_i (.clk(clk), .resetn(resetn), .pulse_in(pulse_in), .cfg(cfg),
      .hold(hold), .reset_cmd(reset_cmd), .remote_preset_value(remote_preset_value),
      .hw_fault(hw_fault), .force_en(force_en), .force_value(force_value),
      .engineering_units(engineering_units), .rate(rate), .preset_output(preset_output),
      .flags(flags));
   pic_pulse_source pic_pulse_source_i (.clk(clk), .ch(cfg.channel_sel), .run(run),
      .pulse_in(pulse_in));

   // ==========================================================
   // Tasks, entered just after a falling edge, save the first cyc at time 0 and a timeout finish_test
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic note(input logic [1:0] k, input logic [31:0] v);
      q.push_back({k, v});
   endtask
   task automatic pulses(input int c, input int s);
      run = 1'b1;
      cyc(2 * c);
      run = 1'b0;
      cyc(s);
   endtask
   task automatic clr();
      reset_cmd = 1'b1;
      cyc(2);
      reset_cmd = 1'b0;
      cyc(2);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Monitor: kind 0 count, 1 rate, 2 {output, flags}
   always @(negedge clk)
   begin
      #1;
      while (q.size() > 0)
      begin
         e = q.pop_front();
         got = e[33:32] == 2'h0 ? engineering_units
             : e[33:32] == 2'h1 ? rate : 32'({preset_output, flags});
         num_checks++;
         if (got !== e[31:0])
         begin
            n_mismatch++;
            $display("mismatch at %0t: kind %0d got %0h want %0h", $time, e[33:32], got, e[31:0]);
         end
      end
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   // ==========================================================
   // Scenarios
   initial
   begin
      void'($urandom(53));
      cyc(20);
      resetn = 1'b1;
      cyc(2);
      for (int c = 0; c <= 4; c++)
      begin
         cfg.channel_sel = 3'(c);
         w = $urandom_range(1, 4);
         n = $urandom_range(8, 40);
         cfg.pulses_per_eu = 32'(w);
         clr();
         pulses(n, 200);
         note(2'h0, c == 0 ? 32'h0 : 32'(n / w));
         note(2'h2, 32'h0);
      end
      cfg.channel_sel = 3'($urandom_range(1, 4));
      cfg.pulses_per_eu = 32'h1;
      clr();
      pulses(6, 200);
      hold = 1'b1;
      pulses(4, 200);
      note(2'h0, 32'h6);
      force_value = $urandom;
      force_en = 1'b1;
      cyc(3);
      note(2'h0, force_value);
      force_en = 1'b0;
      hold = 1'b0;
      cyc(200);
      note(2'h0, 32'h6);
      for (int r = 0; r < 2; r++)
      begin
         cfg.latched_mode = 1'b1;
         cfg.use_remote = r[0];
         cfg.pulses_per_eu = 32'h2;
         cfg.local_preset = r ? 32'h7 : 32'h5;
         remote_preset_value = r ? 32'h5 : 32'h7;
         clr();
         pulses(9, 200);
         note(2'h0, 32'h4);
         note(2'h2, 32'h0);
         pulses(1, 200);
         note(2'h2, 32'hc);
         pulses(3, 200);
         note(2'h2, 32'hc);
         clr();
         note(2'h2, 32'h0);
         note(2'h0, 32'h0);
      end
      cfg.latched_mode = 1'b0;
      cfg.use_remote = 1'b0;
      cfg.pulses_per_eu = 32'h1;
      cfg.local_preset = 32'h3;
      clr();
      pulses(3, 20);
      note(2'h2, 32'hc);
      cyc(200);
      note(2'h2, 32'h0);
      note(2'h0, 32'h0);
      pulses(2, 200);
      note(2'h0, 32'h2);
      cfg.local_preset = 32'h0;
      clr();
      pulses(260, 200);
      note(2'h0, 32'hff);
      note(2'h2, 32'h2);
      hw_fault = 1'b1;
      cyc(1);
      hw_fault = 1'b0;
      cyc(5);
      note(2'h2, 32'h3);
      clr();
      cyc(200);
      note(2'h0, 32'h0);
      note(2'h2, 32'h0);
      w = $urandom_range(1, 5);
      cfg.pulses_per_eu = 32'(w);
      cfg.sample_half_s = 7'($urandom_range(1, 8));
      clr();
      run = 1'b1;
      cyc(12 * SCAN);
      // One pulse per two cycles gives SCAN pulses per second
      for (int p = 0; p < 3; p++)
      begin
         cfg.time_period = pic_pkg::pic_period_t'(p);
         cyc(400);
         note(2'h1, 32'((SCAN * per[p]) / w));
      end
      cfg.sample_half_s = 7'h0;
      cyc(400);
      note(2'h1, 32'h0);
      run = 1'b0;
      cyc(4);
      finish_test();
   end
endmodule

bind pic_pulse_input_counter pic_checker #(.MOMENT_CYC(MOMENT_CYC)) pic_checker_i (
   .clk(clk), .resetn(resetn), .pulse_in(pulse_in), .cfg(cfg), .hold(hold),
   .reset_cmd(reset_cmd), .remote_preset_value(remote_preset_value), .hw_fault(hw_fault),
   .force_en(force_en), .force_value(force_value), .engineering_units(engineering_units),
   .rate(rate), .preset_output(preset_output), .flags(flags));
